/* verilog/fspl_pkg.sv */
// Package for the fan spin-up and loop-limit block: register map, fields,
// reset values, timing constants and carrier structs.
// Assumes a byte-wide register port with printed offsets as addresses.
package fspl_pkg;
  localparam logic [7:0] FSPL_ADDR_GAIN = 8'h45;
  localparam logic [7:0] FSPL_ADDR_SPIN = 8'h46;
  localparam logic [7:0] FSPL_ADDR_STEP = 8'h47;
  localparam logic [7:0] FSPL_ADDR_FLOOR = 8'h48;
  localparam logic [7:0] FSPL_ADDR_VALID = 8'h49;
  localparam logic [7:0] FSPL_ADDR_CTRL = 8'h60;
  localparam logic [7:0] FSPL_ADDR_STAT = 8'h61;
  localparam logic [7:0] FSPL_ADDR_DRIVE = 8'h62;

  localparam logic [7:0] FSPL_RST_GAIN = 8'h2a;
  localparam logic [7:0] FSPL_RST_SPIN = 8'h19;
  localparam logic [7:0] FSPL_RST_STEP = 8'h10;
  localparam logic [7:0] FSPL_RST_FLOOR = 8'h66;
  localparam logic [7:0] FSPL_RST_VALID = 8'hf5;

  localparam logic [7:0] FSPL_DUTY_FULL = 8'hff;
  localparam logic [7:0] FSPL_DUTY_OFF = 8'h00;
  localparam logic [7:0] FSPL_TARGET_OFF = 8'hff;
  localparam logic [5:0] FSPL_STEP_MASK = 6'h3f;
  // Spin levels 30%..65% of 255, in 5% steps
  localparam logic [7:0] FSPL_LVL_BASE = 8'h4d;
  localparam logic [7:0] FSPL_LVL_INC = 8'h0d;
  localparam logic [1:0] FSPL_DER_DEFAULT = 2'h3;

  localparam int FSPL_CLK_MHZ = 250;
  localparam int FSPL_SPIN_BASE_MS = 250;
  localparam int FSPL_UPD_BASE_MS = 100;
  localparam int FSPL_SPIN_BASE_CYC = FSPL_SPIN_BASE_MS * 1000 * FSPL_CLK_MHZ;
  localparam int FSPL_UPD_BASE_CYC = FSPL_UPD_BASE_MS * 1000 * FSPL_CLK_MHZ;

  typedef enum logic [3:0] {
    FSPL_IDLE = 4'h1,
    FSPL_KICK = 4'h2,
    FSPL_LEVEL = 4'h4,
    FSPL_RUN = 4'h8
  } fspl_state_e;

  typedef struct packed {
    logic [1:0] drive_fail_window;
    logic skip_full_kick;
    logic [2:0] spinup_drive_level;
    logic [1:0] spinup_duration;
  } fspl_spin_s;

  typedef struct packed {
    fspl_state_e st;
    logic [7:0] gain;
    fspl_spin_s spin;
    logic [7:0] step;
    logic [7:0] floor;
    logic [7:0] valid;
    logic [7:0] rdata;
    logic [31:0] spin_cnt;
    logic [31:0] upd_cnt;
    logic [6:0] fail_cnt;
    logic [7:0] drive;
    logic [7:0] prev_target;
    logic [7:0] prev_direct;
    logic spin_fail;
    logic drive_fail;
  } fspl_state_s;
endpackage

/* verilog/fspl_top.sv */
// Fan spin-up, ramp limit, minimum drive and stall supervision.
// Assumes the loop core, tach measurement and LUT sit outside and feed in.
// How it works
// - Gain codes select 1x,2x,4x,8x; 4x reset
// - Fail window off, or 16/32/64 updates
// - Kick: full duty for quarter duration
// - Skip kick: level for whole duration
// - Level 30% to 65% in 5% steps
// - Duration 250ms,500ms,1s,2s; 500ms reset
// - No valid tach at end: interrupt
// - Closed loop retries right after failure
// - Five config registers obey software lock
// - Six-bit max step caps drive change
// - Any mode may ramp-limit; loop consults step
// - Default derivative options bypass step limit
// - Loop never below floor, except target FFh
// - Floor unused outside closed loop
// - Floor is eight bits, reset 66h
// - Stopped fan restarted in closed loop
// - Valid count is upper tach byte
// - End of spin-up compares tach to valid
// - Tach above valid: stall, auto spin-up in closed loop only
// - Open loop spins up leaving 00h
// - Target above valid ignored, drive kept
// - Update interval 100ms..1600ms sets period
// - Target FFh off; leaving it spins up
// - Drive at FFh, slow fan: drive fail
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module fspl_top import fspl_pkg::*; #(
  parameter int SPIN_BASE_CYC = FSPL_SPIN_BASE_CYC,
  parameter int UPD_BASE_CYC = FSPL_UPD_BASE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sw_lock,
  // Neighbouring configuration and measurement
  input wire logic closed_loop_speed_control,
  input wire logic ramp_enable,
  input wire logic [1:0] der_opt,
  input wire logic [2:0] update_time,
  input wire logic [7:0] tach_target,
  input wire logic [7:0] tach_reading,
  input wire logic tach_valid,
  input wire logic [7:0] fail_band,
  input wire logic [7:0] loop_request,
  input wire logic [7:0] direct_setting,
  // Outputs
  output logic [7:0] pwm_drive,
  output logic [3:0] proportional_gain,
  output logic [3:0] integral_gain,
  output logic [3:0] derivative_gain,
  output logic spinup_active,
  output logic spin_fail_irq,
  output logic drive_fail_irq
);
  fspl_state_s r_q, r_d;

  function automatic logic [3:0] gain_mult(input logic [1:0] c);
    gain_mult = 4'h1 << c;
  endfunction

  function automatic logic [31:0] upd_mult(input logic [2:0] c);
    case (c)
      3'h5: upd_mult = 32'h8;
      3'h6: upd_mult = 32'hc;
      3'h7: upd_mult = 32'h10;
      default: upd_mult = 32'({29'h0, c} + 32'h1);
    endcase
  endfunction

  logic [31:0] spin_total;
  logic [31:0] upd_total;
  logic [7:0] spin_level;
  logic [6:0] fail_limit;
  logic update_tick;
  logic stall;
  logic target_ok;
  logic use_step;
  logic [7:0] want;
  logic [7:0] stepped;
  logic [7:0] diff;
  logic wr_ok;
  logic [7:0] slow_limit;

  always_comb begin
    spin_total = 32'(SPIN_BASE_CYC) << r_q.spin.spinup_duration;
    upd_total = 32'(UPD_BASE_CYC) * upd_mult(update_time);
    spin_level = 8'(FSPL_LVL_BASE +
      8'({5'h0, r_q.spin.spinup_drive_level}) * FSPL_LVL_INC);
    case (r_q.spin.drive_fail_window)
      2'h1: fail_limit = 7'd16;
      2'h2: fail_limit = 7'd32;
      2'h3: fail_limit = 7'd64;
      default: fail_limit = 7'd0;
    endcase
    update_tick = (r_q.upd_cnt >= upd_total - 32'h1);
    stall = tach_reading > r_q.valid;
    target_ok = tach_target <= r_q.valid;
    // Step derivative bypasses the cap, so the default options skip it
    use_step = closed_loop_speed_control ? !der_opt[1]
                                         : ramp_enable;
    want = closed_loop_speed_control ? (target_ok ? loop_request : r_q.drive)
                                     : direct_setting;
    if (closed_loop_speed_control && want < r_q.floor) begin
      want = r_q.floor;
    end
    diff = (want > r_q.drive) ? 8'(want - r_q.drive) : 8'(r_q.drive - want);
    stepped = want;
    if (use_step && diff > {2'h0, r_q.step[5:0]}) begin
      stepped = (want > r_q.drive) ? 8'(r_q.drive + {2'h0, r_q.step[5:0]})
                                   : 8'(r_q.drive - {2'h0, r_q.step[5:0]});
    end
    slow_limit = (tach_target > ~fail_band) ? FSPL_DUTY_FULL
                                            : 8'(tach_target + fail_band);
    wr_ok = reg_wr && !sw_lock;
  end

  always_comb begin
    r_d = r_q;
    r_d.rdata = 8'h00;
    r_d.prev_target = tach_target;
    r_d.prev_direct = direct_setting;
    r_d.upd_cnt = update_tick ? 32'h0 : r_q.upd_cnt + 32'h1;
    if (wr_ok) begin
      case (reg_addr)
        FSPL_ADDR_GAIN: r_d.gain = {2'h0, reg_wdata[5:0]};
        FSPL_ADDR_SPIN: r_d.spin = reg_wdata;
        FSPL_ADDR_STEP: r_d.step = {2'h0, reg_wdata[5:0]};
        FSPL_ADDR_FLOOR: r_d.floor = reg_wdata;
        FSPL_ADDR_VALID: r_d.valid = reg_wdata;
        default: ;
      endcase
    end
    // Status bits clear when written with 1, even under lock; a new event wins
    if (reg_wr && reg_addr == FSPL_ADDR_STAT) begin
      r_d.spin_fail = r_q.spin_fail & ~reg_wdata[0];
      r_d.drive_fail = r_q.drive_fail & ~reg_wdata[1];
    end
    if (reg_rd) begin
      case (reg_addr)
        FSPL_ADDR_GAIN: r_d.rdata = r_q.gain;
        FSPL_ADDR_SPIN: r_d.rdata = r_q.spin;
        FSPL_ADDR_STEP: r_d.rdata = r_q.step;
        FSPL_ADDR_FLOOR: r_d.rdata = r_q.floor;
        FSPL_ADDR_VALID: r_d.rdata = r_q.valid;
        FSPL_ADDR_CTRL: r_d.rdata = {4'h0, r_q.st};
        FSPL_ADDR_STAT: r_d.rdata = {6'h0, r_q.drive_fail, r_q.spin_fail};
        FSPL_ADDR_DRIVE: r_d.rdata = r_q.drive;
        default: r_d.rdata = 8'h00;
      endcase
    end
    case (r_q.st)
      FSPL_IDLE: begin
        r_d.drive = FSPL_DUTY_OFF;
        r_d.spin_cnt = 32'h0;
        if (closed_loop_speed_control) begin
          if (tach_target != FSPL_TARGET_OFF) begin
            r_d.st = r_q.spin.skip_full_kick ? FSPL_LEVEL : FSPL_KICK;
          end
        end else if (direct_setting != FSPL_DUTY_OFF) begin
          r_d.st = r_q.spin.skip_full_kick ? FSPL_LEVEL : FSPL_KICK;
        end
      end
      FSPL_KICK: begin
        r_d.drive = FSPL_DUTY_FULL;
        r_d.spin_cnt = r_q.spin_cnt + 32'h1;
        if (r_q.spin_cnt >= (spin_total >> 2) - 32'h1) begin
          r_d.st = FSPL_LEVEL;
        end
      end
      FSPL_LEVEL: begin
        r_d.drive = spin_level;
        r_d.spin_cnt = r_q.spin_cnt + 32'h1;
        if (r_q.spin_cnt >= spin_total - 32'h1) begin
          r_d.spin_cnt = 32'h0;
          if (!tach_valid || stall) begin
            r_d.spin_fail = 1'b1;
            if (closed_loop_speed_control) begin
              r_d.st = r_q.spin.skip_full_kick ? FSPL_LEVEL
                                               : FSPL_KICK;
            end else begin
              r_d.st = FSPL_RUN;
            end
          end else begin
            r_d.st = FSPL_RUN;
          end
        end
      end
      FSPL_RUN: begin
        r_d.spin_cnt = 32'h0;
        if (closed_loop_speed_control && tach_target == FSPL_TARGET_OFF) begin
          r_d.drive = FSPL_DUTY_OFF;
          r_d.st = FSPL_IDLE;
        end else if (!closed_loop_speed_control &&
                     direct_setting == FSPL_DUTY_OFF) begin
          r_d.drive = FSPL_DUTY_OFF;
          r_d.st = FSPL_IDLE;
        end else if (closed_loop_speed_control && stall) begin
          r_d.st = r_q.spin.skip_full_kick ? FSPL_LEVEL
                                           : FSPL_KICK;
        end else if (closed_loop_speed_control && update_tick) begin
          r_d.drive = stepped;
        end else if (!closed_loop_speed_control) begin
          if (!use_step) begin
            r_d.drive = want;
          end else if (update_tick) begin
            r_d.drive = stepped;
          end
        end
        // Drive-fail counting in update periods at full drive
        if (fail_limit == 7'd0 || r_q.drive != FSPL_DUTY_FULL ||
            tach_reading <= slow_limit) begin
          r_d.fail_cnt = 7'd0;
        end else if (update_tick) begin
          r_d.fail_cnt = r_q.fail_cnt + 7'd1;
          if (r_q.fail_cnt + 7'd1 >= fail_limit) begin
            r_d.drive_fail = 1'b1;
            r_d.fail_cnt = 7'd0;
          end
        end
      end
      default: r_d.st = FSPL_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{st: FSPL_IDLE, gain: FSPL_RST_GAIN, spin: FSPL_RST_SPIN,
               step: FSPL_RST_STEP, floor: FSPL_RST_FLOOR,
               valid: FSPL_RST_VALID, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign pwm_drive = r_q.drive;
  assign proportional_gain = gain_mult(r_q.gain[1:0]);
  assign integral_gain = gain_mult(r_q.gain[3:2]);
  assign derivative_gain = gain_mult(r_q.gain[5:4]);
  assign spinup_active = (r_q.st == FSPL_KICK) || (r_q.st == FSPL_LEVEL);
  assign spin_fail_irq = r_q.spin_fail;
  assign drive_fail_irq = r_q.drive_fail;
endmodule // fspl_top

/* dv/fspl_fan_model.sv */
// Behavioural fan: spins once its drive has stayed at or above 40h.
// A held stuck input models a jammed rotor for stall scenarios.
`timescale 1ns/10ps
module fspl_fan_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Drive in, tach out
  input wire logic [7:0] drive,
  input wire logic stuck,
  output logic [7:0] tach_reading,
  output logic tach_valid
);
  logic [2:0] run_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 3'h0;
    end else if (stuck || drive < 8'h40) begin
      run_q <= 3'h0;
    end else if (run_q != 3'h4) begin
      run_q <= run_q + 3'h1;
    end
  end
  // A stopped fan reads the slowest count, so it always looks stalled
  assign tach_valid = (run_q == 3'h4);
  assign tach_reading = tach_valid ? 8'h40 : 8'hff;
endmodule // fspl_fan_model

/* dv/fspl_monitor.sv */
// Checker for the register port, gains and spin-up drive.
// Bound to fspl_top; sees its ports only.
`timescale 1ns/10ps
module fspl_monitor import fspl_pkg::*; #(
  parameter int SPIN_BASE_CYC = 40,
  parameter int UPD_BASE_CYC = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sw_lock,
  // Loop inputs
  input wire logic closed_loop_speed_control,
  input wire logic [7:0] tach_target,
  input wire logic [7:0] direct_setting,
  // Outputs
  input wire logic [7:0] pwm_drive,
  input wire logic [3:0] proportional_gain,
  input wire logic [3:0] integral_gain,
  input wire logic [3:0] derivative_gain,
  input wire logic spinup_active,
  input wire logic spin_fail_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_off_zero;
    !closed_loop_speed_control && !spinup_active && pwm_drive == 8'h00
      && direct_setting == 8'h00;
  endsequence
  sequence s_leave_zero;
    !closed_loop_speed_control && direct_setting != 8'h00;
  endsequence
  a_gain_decode: assert property (
    reg_wr && reg_addr == FSPL_ADDR_GAIN && !sw_lock |=>
    proportional_gain == (4'h1 << $past(reg_wdata[1:0])) &&
    integral_gain == (4'h1 << $past(reg_wdata[3:2])) &&
    derivative_gain == (4'h1 << $past(reg_wdata[5:4])))
    else $error("gain outputs do not follow written codes");
  a_lock_blocks: assert property (
    sw_lock && reg_wr && reg_addr == FSPL_ADDR_GAIN |=>
    $stable(proportional_gain) && $stable(derivative_gain))
    else $error("locked gain write took effect");
  a_gain_reserved: assert property (
    reg_rd && reg_addr == FSPL_ADDR_GAIN |=> reg_rdata[7:6] == 2'b00)
    else $error("gain unused bits read nonzero");
  a_spin_level: assert property (
    spinup_active && $past(spinup_active) && pwm_drive != 8'hff |->
    pwm_drive inside {8'h4d, 8'h5a, 8'h67, 8'h74, 8'h81, 8'h8e, 8'h9b,
    8'ha8})
    else $error("spin-up drive is neither full nor a level");
  a_target_off: assert property (
    (closed_loop_speed_control && tach_target == 8'hff && !spinup_active)[*3]
    |-> pwm_drive == 8'h00)
    else $error("drive not off with target at ffh");
  a_open_spin: assert property (
    s_off_zero ##1 s_leave_zero |-> ##[0:2] spinup_active)
    else $error("open loop did not spin up leaving zero");
  a_retry_fail: assert property (
    $rose(spin_fail_irq) && closed_loop_speed_control |->
    ##[0:1] spinup_active)
    else $error("closed loop did not retry after failed spin-up");
  a_fail_sticky: assert property (
    spin_fail_irq && !(reg_wr && reg_addr == FSPL_ADDR_STAT) |=>
    spin_fail_irq)
    else $error("spin fail flag dropped without a clear");
endmodule // fspl_monitor

bind fspl_top fspl_monitor #(.SPIN_BASE_CYC(SPIN_BASE_CYC),
  .UPD_BASE_CYC(UPD_BASE_CYC)) u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_lock(sw_lock),
  .closed_loop_speed_control(closed_loop_speed_control),
  .tach_target(tach_target), .direct_setting(direct_setting),
  .pwm_drive(pwm_drive), .proportional_gain(proportional_gain),
  .integral_gain(integral_gain), .derivative_gain(derivative_gain),
  .spinup_active(spinup_active), .spin_fail_irq(spin_fail_irq));

/* dv/fan_spinup_and_loop_limits_test.sv */
// Self-checking bench for fspl_top driving a behavioural fan.
// Assumes shortened spin (40) and update (20) bases, one clock.
`timescale 1ns/10ps
module fan_spinup_and_loop_limits_test import fspl_pkg::*;;
  logic ref_clk = 0, rst_n = 0, wr = 0, rd = 0, lock = 0, cl = 0, ramp = 0;
  logic [2:0] utime = 3'h0;
  logic stuck = 0, tvalid, spin, sfail, dfail;
  logic [7:0] addr = 0, wdata = 0, dset = 0, target = 8'h40, got;
  logic [7:0] rdata, pwm, tread;
  logic [3:0] pg, ig, dg;
  logic [7:0] rv [5] = '{8'h2a, 8'h19, 8'h10, 8'h66, 8'hf5};
  int errors = 0, checks_done = 0, cyc = 0, n;
  initial forever #2 ref_clk = ~ref_clk;
  fspl_top #(.SPIN_BASE_CYC(40), .UPD_BASE_CYC(20)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .sw_lock(lock),
    .closed_loop_speed_control(cl), .ramp_enable(ramp), .der_opt(2'h3),
    .update_time(utime), .tach_target(target), .tach_reading(tread),
    .tach_valid(tvalid), .fail_band(8'h00), .loop_request(8'h10),
    .direct_setting(dset), .pwm_drive(pwm), .proportional_gain(pg),
    .integral_gain(ig), .derivative_gain(dg), .spinup_active(spin),
    .spin_fail_irq(sfail), .drive_fail_irq(dfail));
  fspl_fan_model u_fan (.ref_clk(ref_clk), .rst_n(rst_n), .drive(pwm),
    .stuck(stuck), .tach_reading(tread), .tach_valid(tvalid));
  task automatic finish_test;
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e);
    checks_done++;
    if (g != e) begin
      errors++;
      $display("BAD %0t count %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Length of the next unbroken run of one drive value
  task automatic run_len(input logic [7:0] v, output int k);
    int t;
    t = 0;
    k = 0;
    while (pwm !== v && t < 2000) begin
      @(posedge ref_clk) #1 t++;
    end
    while (pwm === v && k < 2000) begin
      @(posedge ref_clk) #1 k++;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_reg(8'h45 + i[7:0], got);
      chk(got, rv[i]);
    end
    chk({pg, ig}, 8'h44);
    rd_reg(8'h50, got);
    chk(got, 8'h00);
    wr_reg(8'h47, 8'hff);
    rd_reg(8'h47, got);
    chk(got, 8'h3f);
    wr_reg(8'h48, 8'h80);
    rd_reg(8'h48, got);
    chk(got, 8'h80);
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h45, {2'b11, c[1:0], c[1:0], c[1:0]});
      chk({dg, pg}, {4'h1 << c, 4'h1 << c});
      rd_reg(8'h45, got);
      chk(got, {2'b00, c[1:0], c[1:0], c[1:0]});
    end
    lock <= 1'b1;
    wr_reg(8'h46, 8'h00);
    wr_reg(8'h45, 8'h00);
    lock <= 1'b0;
    rd_reg(8'h46, got);
    chk(got, 8'h19);
    rd_reg(8'h45, got);
    chk(got, 8'h3f);
    wr_reg(8'h46, 8'h40);
    dset <= 8'h80;
    run_len(8'hff, n);
    chk_n(n, 10);
    run_len(8'h4d, n);
    chk_n(n, 30);
    for (int c = 0; c < 4; c++) begin
      dset <= 8'h00;
      repeat (5) @(posedge ref_clk);
      wr_reg(8'h46, {3'b001, c[2:0], c[1:0]});
      dset <= 8'h80;
      run_len(8'h4d + 8'h0d * c[7:0], n);
      chk_n(n, 40 << c);
    end
    dset <= 8'h00;
    stuck <= 1'b1;
    wr_reg(8'h46, 8'h41);
    cl <= 1'b1;
    for (n = 0; n < 400 && sfail !== 1'b1; n++) @(posedge ref_clk) #1;
    chk({7'h0, sfail}, 8'h01);
    chk({7'h0, spin}, 8'h01);
    stuck <= 1'b0;
    repeat (300) @(posedge ref_clk);
    #1 chk(pwm, 8'h80);
    wr_reg(8'h61, 8'h03);
    rd_reg(8'h61, got);
    chk(got, 8'h00);
    stuck <= 1'b1;
    for (n = 0; n < 60 && spin !== 1'b1; n++) @(posedge ref_clk) #1;
    chk({7'h0, spin}, 8'h01);
    stuck <= 1'b0;
    target <= 8'hff;
    repeat (400) @(posedge ref_clk);
    #1 chk(pwm, 8'h00);
    // Open-loop ramp at 3fh per 200ms period, then full drive on a fast
    // target so the fail window runs out after 16 periods
    cl <= 1'b0;
    ramp <= 1'b1;
    utime <= 3'h1;
    target <= 8'h20;
    dset <= 8'hff;
    run_len(8'h8c, n);
    chk_n(n, 40);
    run_len(8'hcb, n);
    chk_n(n, 40);
    chk({7'h0, dfail}, 8'h00);
    for (n = 0; n < 700 && dfail !== 1'b1; n++) @(posedge ref_clk) #1;
    chk_n(n, 640);
    finish_test();
  end
endmodule // fan_spinup_and_loop_limits_test
